// *** dcra_pkg.sv ***
// Shared constants, types and helpers for the audio front end
// Summary of operation
// - Device detects clock ratio automatically, 128 to 768
// - Source gives over 256 fs at 128 fs
// - No 512 or 768 fs at 192 kHz
// - Power-on reset runs 1024-cycle initialization
// - Initialization restores default mode settings
// - Reset pin low 20 ns; rise starts init
// - Data sampled on bit clock rising edge
// - Word clock frequency-locked to system clock
// - Drift over 6 bit clocks: resync, mute
// - Format field selects RJ, I2S or LJ
// - Format defaults to 32-bit I2S
// - Samples are two's complement, MSB first
// - RJ/LJ: word clock high means left
// - I2S: word clock low means left
// - Bypass bit selects external filter mode
// - Stereo bit turns zero pins into data, in bypass mode only
package dcra_pkg;
    localparam int REF_CLK_MHZ  = 50;
    localparam int INIT_CYC     = 1024;
    localparam int RST_LOW_NS   = 20;
    localparam int RST_LOW_CYC  =
        (RST_LOW_NS * REF_CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (RST_LOW_NS * REF_CLK_MHZ + 999) / 1000;
    // Margin for the three-stage pin filter in the device
    localparam int RST_HOLD_CYC = RST_LOW_CYC + 3;
    localparam int DRIFT_BCK    = 6;
    localparam int SLOTS_LOG2   = 6;
    localparam int RATIO_TOL    = 4;
    localparam int BCK_HALF_DEF = 2;

    localparam logic [2:0] FMT_RJ16 = 3'h0;
    localparam logic [2:0] FMT_RJ20 = 3'h1;
    localparam logic [2:0] FMT_RJ24 = 3'h2;
    localparam logic [2:0] FMT_I2S  = 3'h4;
    localparam logic [2:0] FMT_LJ   = 3'h5;
    localparam logic [2:0] FMT_RST  = FMT_I2S;

    localparam logic [3:0]  REG_CTRL = 4'h0;
    localparam logic [3:0]  REG_LEFT = 4'h4;
    localparam logic [3:0]  REG_RGHT = 4'h8;
    localparam logic [3:0]  REG_STAT = 4'hC;
    localparam int          CTRL_RUN = 0;
    localparam int          CTRL_FMT = 1;
    localparam int          CTRL_BYP = 4;
    localparam int          CTRL_STE = 5;
    localparam int          CTRL_RST = 8;
    localparam int          STAT_TKN = 0;
    localparam int          STAT_RBY = 1;
    localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0008;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    typedef enum logic [1:0] {ST_INIT, ST_HUNT, ST_LOCK} dcra_sync_t;

    function automatic logic is_i2s(input logic [2:0] f);
        return f == FMT_I2S || f[2:1] == 2'b11;
    endfunction : is_i2s

    // Left shift that moves a right-justified word to the MSB
    function automatic logic [4:0] rj_shift(input logic [2:0] f);
        unique case (f)
            FMT_RJ16: return 5'h10;
            FMT_RJ20: return 5'h0C;
            FMT_RJ24: return 5'h08;
            default:  return 5'h00;
        endcase
    endfunction : rj_shift

    function automatic logic [11:0] absdiff(input logic [11:0] a,
                                            input logic [11:0] b);
        return a > b ? a - b : b - a;
    endfunction : absdiff

    // Code 0..5 for 128,192,256,384,512,768 fs; 7 when unknown
    function automatic logic [2:0] ratio_code(input logic [11:0] c);
        logic [2:0] r;
        r = 3'h7;
        if (absdiff(c, 12'h080) <= RATIO_TOL) r = 3'h0;
        if (absdiff(c, 12'h0C0) <= RATIO_TOL) r = 3'h1;
        if (absdiff(c, 12'h100) <= RATIO_TOL) r = 3'h2;
        if (absdiff(c, 12'h180) <= RATIO_TOL) r = 3'h3;
        if (absdiff(c, 12'h200) <= RATIO_TOL) r = 3'h4;
        if (absdiff(c, 12'h300) <= RATIO_TOL) r = 3'h5;
        return r;
    endfunction : ratio_code
endpackage : dcra_pkg

// *** dcra_if.sv ***
// Serial audio link between source and converter front end
`timescale 1ns/1ps
interface dcra_if;
    logic rst_n;
    logic serial_bit_clk;
    logic lr_word_clk;
    logic audio_data;
    logic zl_dev_o;
    logic zl_dev_oe;
    logic zr_dev_o;
    logic zr_dev_oe;
    logic zl_host_o;
    logic zl_host_oe;
    logic zr_host_o;
    logic zr_host_oe;
    logic left_zero_flag;
    logic right_zero_flag;

    // Pin levels; an undriven pin reads low
    assign left_zero_flag  = zl_dev_oe ? zl_dev_o :
                             zl_host_oe ? zl_host_o : 1'b0;
    assign right_zero_flag = zr_dev_oe ? zr_dev_o :
                             zr_host_oe ? zr_host_o : 1'b0;

    modport dev (input rst_n, serial_bit_clk, lr_word_clk, audio_data,
                 left_zero_flag, right_zero_flag,
                 output zl_dev_o, zl_dev_oe, zr_dev_o, zr_dev_oe);
    modport host (output rst_n, serial_bit_clk, lr_word_clk, audio_data,
                  zl_host_o, zl_host_oe, zr_host_o, zr_host_oe,
                  input left_zero_flag, right_zero_flag);
endinterface : dcra_if

// *** dcra_dev_end.sv ***
// Converter end: reset, clock ratio detect and serial audio input
`timescale 1ns/1ps
module dcra_dev_end import dcra_pkg::*; (
    input  wire logic        ref_clk,      // System clock
    input  wire logic        srst,         // Power-on reset
    dcra_if.dev              lnk,          // Audio link
    input  wire logic        mode_wr,      // Mode write strobe
    input  wire logic [2:0]  mode_fmt,     // New audio_format_sel
    input  wire logic        mode_byp,     // New filter_bypass_en
    input  wire logic        mode_ste,     // New ext_filter_stereo_en
    output logic      [2:0]  audio_format_sel,     // Current format
    output logic             filter_bypass_en,     // Current bypass
    output logic             ext_filter_stereo_en, // Current stereo
    output logic             init_busy,    // Initialization running
    output logic             locked,       // Word clock in sync
    output logic      [2:0]  ratio,        // Detected ratio code
    output logic             samp_valid,   // New sample pair pulse
    output logic      [31:0] samp_left,    // Left sample, MSB aligned
    output logic      [31:0] samp_right    // Right sample, MSB aligned
);
    // ---------------- System clock domain ----------------
    dcra_sync_t  state_q;
    logic [10:0] init_cnt_q;
    logic [2:0]  rst_s_q;
    logic        rstf_q;
    logic [2:0]  lr_s_q;
    logic        lrf_q;
    logic [11:0] per_cnt_q;
    logic [11:0] per_q;
    logic [2:0]  ratio_q;
    logic [2:0]  tg_s_q;
    logic        tg_seen_q;
    logic [2:0]  fmt_q;
    logic        byp_q;
    logic        ste_q;
    logic        svalid_q;
    logic [31:0] sl_q;
    logic [31:0] sr_q;
    logic        mute_q;
    // Written in the bit clock domain, read once qualified by toggle
    logic [31:0] wl_q;
    logic [31:0] wr_q;
    logic        tgl_q;

    wire rst_stable = rst_s_q[1] == rst_s_q[2];
    wire lr_stable  = lr_s_q[1] == lr_s_q[2];
    wire lr_rise    = lr_stable && lr_s_q[2] && !lrf_q;
    wire [2:0]  cur_ratio = ratio_code(per_cnt_q);
    wire [15:0] tol_w  = (16'(per_q) * 16'(DRIFT_BCK)) >> SLOTS_LOG2;
    wire        match  = absdiff(per_cnt_q, per_q) <= tol_w[11:0];
    wire        stall  = &per_cnt_q;
    wire        tg_evt = tg_s_q[1] == tg_s_q[2] && tg_s_q[2] != tg_seen_q;
    wire        muted  = state_q != ST_LOCK;

    always_ff @(posedge ref_clk) begin
        rst_s_q <= {rst_s_q[1:0], lnk.rst_n};
        if (srst)
            rstf_q <= 1'b1;
        else if (rst_stable)
            rstf_q <= rst_s_q[2];
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !rstf_q) begin
            state_q    <= ST_INIT;
            init_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_INIT: begin
                    init_cnt_q <= init_cnt_q + 11'h001;
                    if (init_cnt_q == 11'(INIT_CYC - 1))
                        state_q <= ST_HUNT;
                end
                ST_HUNT: begin
                    if (lr_rise && cur_ratio != 3'h7 && match)
                        state_q <= ST_LOCK;
                end
                ST_LOCK: begin
                    if ((lr_rise && !match) || stall)
                        state_q <= ST_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        lr_s_q <= {lr_s_q[1:0], lnk.lr_word_clk};
        if (srst) begin
            lrf_q     <= 1'b0;
            per_cnt_q <= '0;
            per_q     <= '0;
            ratio_q   <= 3'h7;
        end else begin
            if (lr_stable)
                lrf_q <= lr_s_q[2];
            if (lr_rise) begin
                per_cnt_q <= 12'h001;
                per_q     <= per_cnt_q;
                ratio_q   <= cur_ratio;
            end else if (!stall) begin
                per_cnt_q <= per_cnt_q + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || state_q == ST_INIT) begin
            fmt_q <= FMT_RST;
            byp_q <= 1'b0;
            ste_q <= 1'b0;
        end else if (mode_wr) begin
            fmt_q <= mode_fmt;
            byp_q <= mode_byp;
            ste_q <= mode_ste;
        end
    end

    always_ff @(posedge ref_clk) begin
        tg_s_q <= {tg_s_q[1:0], tgl_q};
        mute_q <= muted;
        if (srst) begin
            tg_seen_q <= 1'b0;
            svalid_q  <= 1'b0;
            sl_q      <= '0;
            sr_q      <= '0;
        end else begin
            svalid_q <= tg_evt;
            if (tg_evt) begin
                tg_seen_q <= tg_s_q[2];
                sl_q      <= muted ? 32'h0000_0000 : wl_q;
                sr_q      <= muted ? 32'h0000_0000 : wr_q;
            end
        end
    end

    assign audio_format_sel     = fmt_q;
    assign filter_bypass_en     = byp_q;
    assign ext_filter_stereo_en = ste_q;
    assign init_busy  = state_q == ST_INIT;
    assign locked     = state_q == ST_LOCK;
    assign ratio      = ratio_q;
    assign samp_valid = svalid_q;
    assign samp_left  = sl_q;
    assign samp_right = sr_q;
    assign lnk.zl_dev_o  = 1'b0;
    assign lnk.zr_dev_o  = 1'b0;
    assign lnk.zl_dev_oe = !(byp_q && ste_q);
    assign lnk.zr_dev_oe = !(byp_q && ste_q);

    // ---------------- Bit clock domain ----------------
    logic [2:0]  ini_s_q;
    logic [4:0]  cfg_a_q;
    logic [4:0]  cfg_b_q;
    logic [4:0]  cfg_c_q;
    logic [4:0]  cfg_q;
    logic        lr_q;
    logic [31:0] sh_q;
    logic [31:0] shl_q;
    logic [31:0] shr_q;
    logic        pend_q;
    logic        pend_lr_q;

    // Held in reset until locked; bit clock may idle through init
    wire        brst   = ini_s_q[1] && ini_s_q[2];
    wire [2:0]  b_fmt  = cfg_q[4:2];
    wire        b_byp  = cfg_q[1];
    wire        b_ste  = cfg_q[0];
    wire        lr_chg = lnk.lr_word_clk != lr_q;
    wire        i2s    = is_i2s(b_fmt);
    wire [31:0] pcm_w  = sh_q << rj_shift(b_fmt);
    wire        cap_jst = lr_chg && !i2s && !b_byp;
    wire        jst_lft = lr_q;
    wire        cap_i2s = pend_q;
    wire        i2s_lft = !pend_lr_q;
    wire        cap_byp = lr_chg && lnk.lr_word_clk && b_byp;

    always_ff @(posedge lnk.serial_bit_clk) begin
        ini_s_q <= {ini_s_q[1:0], mute_q};
        cfg_a_q <= {fmt_q, byp_q, ste_q};
        cfg_b_q <= cfg_a_q;
        cfg_c_q <= cfg_b_q;
        lr_q  <= lnk.lr_word_clk;
        sh_q  <= {sh_q[30:0], lnk.audio_data};
        shl_q <= {shl_q[30:0], lnk.left_zero_flag};
        shr_q <= {shr_q[30:0], lnk.right_zero_flag};
    end

    always_ff @(posedge lnk.serial_bit_clk) begin
        if (brst) begin
            cfg_q     <= {FMT_RST, 2'b00};
            pend_q    <= 1'b0;
            pend_lr_q <= 1'b0;
            wl_q      <= '0;
            wr_q      <= '0;
            tgl_q     <= 1'b0;
        end else begin
            if (cfg_b_q == cfg_c_q)
                cfg_q <= cfg_c_q;
            pend_q    <= lr_chg && i2s && !b_byp;
            pend_lr_q <= lr_q;
            if ((cap_jst && jst_lft) || (cap_i2s && i2s_lft))
                wl_q <= pcm_w;
            if ((cap_jst && !jst_lft) || (cap_i2s && !i2s_lft)) begin
                wr_q  <= pcm_w;
                tgl_q <= !tgl_q;
            end
            if (cap_byp) begin
                wl_q  <= b_ste ? shl_q : sh_q;
                wr_q  <= b_ste ? shr_q : sh_q;
                tgl_q <= !tgl_q;
            end
        end
    end
endmodule : dcra_dev_end

// *** dcra_host_end.sv ***
// Source end: AXI4-Lite registers, bit clock divider, serializer
`timescale 1ns/1ps
module dcra_host_end import dcra_pkg::*; #(
    parameter int BCK_HALF = BCK_HALF_DEF  // Ref clocks per half bit
) (
    input  wire logic        ref_clk,       // System clock
    input  wire logic        srst,          // Sync reset
    dcra_if.host             lnk,           // Audio link
    input  wire logic [3:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic      [1:0]  s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [3:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic      [31:0] s_axi_rdata,   // Read data
    output logic      [1:0]  s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready   // Read data ready
);
    if (BCK_HALF < 1 || BCK_HALF > 255) begin : g_chk
        $error("BCK_HALF out of range");
    end

    logic [31:0] ctrl_q;
    logic [31:0] left_q;
    logic [31:0] rght_q;
    logic        tkn_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [3:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [3:0]  rcnt_q;
    logic [7:0]  div_q;
    logic        bck_q;
    logic [5:0]  slot_q;
    logic [31:0] shl_q;
    logic [31:0] shr_q;
    logic        lr_q;
    logic        dat_q;
    logic        zl_q;
    logic        zr_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
            if (st[i]) m[i*8 +: 8] = nw[i*8 +: 8];
        return m;
    endfunction : merge

    wire aw_hs  = s_axi_awvalid && s_axi_awready;
    wire w_hs   = s_axi_wvalid && s_axi_wready;
    wire do_wr  = aw_got_q && w_got_q && !bvalid_q;
    wire ar_hs  = s_axi_arvalid && s_axi_arready;
    wire wr_ok  = aw_q == REG_CTRL || aw_q == REG_LEFT ||
                  aw_q == REG_RGHT || aw_q == REG_STAT;
    wire wr_ctl = do_wr && aw_q == REG_CTRL;
    wire rst_go = wr_ctl && ws_q[1] && wd_q[CTRL_RST];
    wire run    = ctrl_q[CTRL_RUN];
    wire [2:0] fmt = ctrl_q[CTRL_FMT +: 3];
    wire byp    = ctrl_q[CTRL_BYP];
    wire ste    = ctrl_q[CTRL_STE];
    wire fall   = run && bck_q && div_q == 8'(BCK_HALF - 1);
    wire [5:0] nxt = slot_q + 6'h01;
    wire [5:0] eff = (is_i2s(fmt) && !byp) ? nxt - 6'h01 : nxt;
    wire [31:0] chw = eff[5] ? shr_q : shl_q;
    wire [31:0] pcm = 32'($signed(chw) >>> rj_shift(fmt));
    wire pcm_bit = pcm[~eff[4:0]];
    wire byp_bit = nxt[5] && shl_q[~nxt[4:0]];
    wire [31:0] stat_w = {30'h0, rcnt_q != 4'h0, tkn_q};

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready  = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            aw_q     <= '0;
            wd_q     <= '0;
            ws_q     <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OK;
            ctrl_q   <= CTRL_RST_VAL;
            left_q   <= '0;
            rght_q   <= '0;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                aw_q     <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wd_q    <= s_axi_wdata;
                ws_q    <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OK : RESP_ERR;
                if (aw_q == REG_LEFT)
                    left_q <= merge(left_q, wd_q, ws_q);
                if (aw_q == REG_RGHT)
                    rght_q <= merge(rght_q, wd_q, ws_q);
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            // Reset request bit never stores
            if (wr_ctl)
                ctrl_q <= merge(ctrl_q, wd_q, ws_q) & ~(32'h1 << CTRL_RST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OK;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OK;
            unique case (s_axi_araddr)
                REG_CTRL: rdata_q <= ctrl_q;
                REG_LEFT: rdata_q <= left_q;
                REG_RGHT: rdata_q <= rght_q;
                REG_STAT: rdata_q <= stat_w;
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_ERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || rst_go)
            rcnt_q <= 4'(RST_HOLD_CYC);
        else if (rcnt_q != 4'h0)
            rcnt_q <= rcnt_q - 4'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !run) begin
            div_q <= '0;
            bck_q <= 1'b0;
        end else if (div_q == 8'(BCK_HALF - 1)) begin
            div_q <= '0;
            bck_q <= !bck_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !run) begin
            slot_q <= 6'h3F;
            lr_q   <= 1'b0;
            dat_q  <= 1'b0;
            zl_q   <= 1'b0;
            zr_q   <= 1'b0;
        end else if (fall) begin
            slot_q <= nxt;
            lr_q   <= (is_i2s(fmt) && !byp) ? nxt[5] : !nxt[5];
            dat_q  <= byp ? byp_bit : pcm_bit;
            zl_q   <= byp_bit;
            zr_q   <= nxt[5] && shr_q[~nxt[4:0]];
        end
    end

    // Shadows refresh while the other channel is on the wire
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            shl_q <= '0;
            shr_q <= '0;
            tkn_q <= 1'b0;
        end else begin
            if (fall && nxt == 6'h3F)
                shl_q <= left_q;
            if (fall && nxt == 6'h1F)
                shr_q <= rght_q;
            // Set wins over a same-cycle clear
            if (fall && nxt == 6'h1F)
                tkn_q <= 1'b1;
            else if (do_wr && aw_q == REG_STAT && ws_q[0] &&
                     wd_q[STAT_TKN])
                tkn_q <= 1'b0;
        end
    end

    assign s_axi_bresp        = bresp_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign s_axi_rvalid       = rvalid_q;
    assign lnk.rst_n          = rcnt_q == 4'h0;
    assign lnk.serial_bit_clk = bck_q;
    assign lnk.lr_word_clk    = lr_q;
    assign lnk.audio_data     = dat_q;
    assign lnk.zl_host_o      = zl_q;
    assign lnk.zr_host_o      = zr_q;
    assign lnk.zl_host_oe     = byp && ste;
    assign lnk.zr_host_oe     = byp && ste;
endmodule : dcra_host_end

// *** dcra_monitor.sv ***
// Link protocol checker for the serial audio interface
`timescale 1ns/1ps
module dcra_monitor (
    input wire logic ref_clk,        // System clock
    input wire logic srst,           // Sync reset
    input wire logic rst_n,          // Reset pin
    input wire logic serial_bit_clk, // Bit clock
    input wire logic lr_word_clk,    // Word clock
    input wire logic audio_data,     // Serial data
    input wire logic zl_dev_o,       // Device left flag
    input wire logic zl_dev_oe,      // Device left enable
    input wire logic zr_dev_oe,      // Device right enable
    input wire logic zl_host_oe      // Host left enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic       lr_q;
    logic       bk_q;
    logic       seen_q;
    logic [6:0] n_q;
    wire        lr_rise = lr_word_clk & ~lr_q;
    wire        bk_rise = serial_bit_clk & ~bk_q;
    // Bit clock rises per frame; first frame and reset pulses restart it
    always_ff @(posedge ref_clk) begin
        lr_q <= lr_word_clk;
        bk_q <= serial_bit_clk;
        seen_q <= !srst && rst_n && (seen_q || lr_rise);
        n_q <= lr_rise ? 7'(bk_rise) : n_q + 7'(bk_rise);
    end
    sequence s_hi_lo;
        serial_bit_clk ##1 !serial_bit_clk;
    endsequence
    sequence s_rst_low;
        !rst_n [*3];
    endsequence
    a_bclk_high: assert property ($rose(serial_bit_clk) |=> s_hi_lo)
        else $error("bit clock high phase wrong");
    a_data_on_fall: assert property ($changed(audio_data) |-> $fell(serial_bit_clk))
        else $error("data moved off falling bit clock");
    a_lr_on_fall: assert property ($changed(lr_word_clk) |-> !serial_bit_clk)
        else $error("word clock moved while bit clock high");
    a_frame_len: assert property (lr_rise && seen_q |-> n_q == 7'd64)
        else $error("frame is not 64 bit clocks");
    a_rst_pulse: assert property ($fell(rst_n) |=> s_rst_low)
        else $error("reset pin pulse too short");
    a_flag_no_clash: assert property (!(zl_dev_oe && zl_host_oe))
        else $error("both ends drive left flag pin");
    a_flag_pair: assert property (zl_dev_oe == zr_dev_oe)
        else $error("flag enables differ");
    a_flag_low: assert property (zl_dev_oe |-> !zl_dev_o)
        else $error("left flag driven high");
endmodule : dcra_monitor

// *** tb.sv ***
// Self-checking bench for both link ends
`timescale 1ns/1ps
module tb;
    import dcra_pkg::*;
    logic        ref_clk = 0, srst = 1, mode_wr = 0, mode_byp = 0;
    logic        mode_ste = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, samp_valid, locked;
    logic        filter_bypass_en, ext_filter_stereo_en, init_busy;
    logic [2:0]  mode_fmt = 0, audio_format_sel, ratio;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, samp_left, samp_right;
    logic [31:0] seed = 32'hAC08, rd, lf, rt;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [2:0]  fmts[3] = '{FMT_I2S, FMT_LJ, FMT_RJ24};
    logic [63:0] exp_q[$];
    int          err_count = 0, num_checks = 0, cyc = 0;
    dcra_if lnk ();
    dcra_dev_end dcra_dev_end_i (.*);
    dcra_host_end #(.BCK_HALF(2)) dcra_host_end_i (.*);
    dcra_monitor dcra_monitor_i (.ref_clk, .srst, .rst_n(lnk.rst_n),
        .serial_bit_clk(lnk.serial_bit_clk), .lr_word_clk(lnk.lr_word_clk),
        .audio_data(lnk.audio_data), .zl_dev_o(lnk.zl_dev_o),
        .zl_dev_oe(lnk.zl_dev_oe), .zr_dev_oe(lnk.zr_dev_oe),
        .zl_host_oe(lnk.zl_host_oe));
    always #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    // Readiness sampled mid-cycle, where the combinational readies are settled
    task automatic axi(input bit w, input logic [3:0] a, input logic [31:0] d);
        bit ta = 0;
        bit tw = !w;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
        {s_axi_arvalid, s_axi_rready} <= {!w, !w};
        while (!(ta && tw)) begin
            @(negedge ref_clk);
            ta = ta || (w ? s_axi_awready : s_axi_arready);
            tw = tw || s_axi_wready;
            @(posedge ref_clk);
            {s_axi_awvalid, s_axi_wvalid} <= {w && !ta, w && !tw};
            s_axi_arvalid <= !w && !ta;
        end
        do @(negedge ref_clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
        rd = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        @(posedge ref_clk);
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask : axi
    task automatic mode(input logic [2:0] f, input logic b, input logic s);
        @(posedge ref_clk);
        {mode_wr, mode_fmt, mode_byp, mode_ste} <= {1'b1, f, b, s};
        @(posedge ref_clk);
        mode_wr <= 0;
    endtask : mode
    task automatic frames(input int k);
        repeat (k) do @(negedge ref_clk); while (!samp_valid);
        @(posedge ref_clk);
    endtask : frames
    task automatic busy_len();
        int n = 0;
        while (!init_busy) @(negedge ref_clk);
        while (init_busy) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= INIT_CYC && n <= INIT_CYC + 12, 1);
    endtask : busy_len
    always @(negedge ref_clk) begin
        if (samp_valid && exp_q.size() > 0) begin
            chk({samp_left, samp_right}, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        @(negedge ref_clk);
        chk(audio_format_sel, FMT_RST);
        chk({filter_bypass_en, ext_filter_stereo_en}, 0);
        axi(0, REG_CTRL, 0);
        chk(rd, CTRL_RST_VAL);
        axi(0, 4'h2, 0);
        chk(rs, RESP_ERR);
        busy_len();
        foreach (fmts[i]) begin
            lf = xs();
            rt = xs();
            axi(1, REG_LEFT, lf);
            axi(1, REG_RGHT, rt);
            // Reset pulse around the switch hides the odd frame
            axi(1, REG_CTRL, 32'({1'b1, 4'h0, fmts[i], 1'b1}));
            busy_len();
            mode(fmts[i], 0, 0);
            while (!locked) @(negedge ref_clk);
            // Older frames may still carry the previous words
            frames(3);
            // right-justified 24 loses the low byte
            exp_q.push_back({lf, rt} & (fmts[i] == FMT_RJ24 ?
                64'hFFFF_FF00_FFFF_FF00 : ~64'h0));
            while (exp_q.size() > 0) @(negedge ref_clk);
            chk(ratio, 3'h2);
        end
        axi(1, REG_CTRL, 32'h0000_010B);
        busy_len();
        chk(audio_format_sel, FMT_RST);
        mode(FMT_I2S, 1, 1);
        axi(1, REG_CTRL, 32'h0000_0039);
        frames(2);
        // stereo words arrive on the flag pins
        exp_q.push_back({lf, rt});
        while (exp_q.size() > 0) @(negedge ref_clk);
        chk({filter_bypass_en, ext_filter_stereo_en}, 2'b11);
        chk({lnk.zl_dev_oe, lnk.zl_host_oe}, 2'b01);
        end_of_test();
    end
endmodule : tb
